// file: logic/spi_pkg.sv
// Package for the serial pin inversion and select block.
// Assumes a 32-bit APB register bus, one 10 MHz clock, synchronous reset.
package spi_pkg;
  // Register index; it counts words, so the byte address is four times it
  localparam logic [15:0] SPI_CTRL_INDEX       = 16'hff91;
  localparam logic [31:0] SPI_CTRL_ADDR        = {14'h0000, SPI_CTRL_INDEX, 2'b00};
  // Value after reset
  localparam logic [7:0]  SPI_CTRL_RESET       = 8'hc0;
  // Bits that always read as one
  localparam logic [7:0]  SPI_CTRL_FIXED_ONES  = 8'hc0;
  // Field positions
  localparam int          SPI_RX_FIRST_INV_BIT = 0;
  localparam int          SPI_TX_FIRST_INV_BIT = 1;
  localparam int          SPI_RX_SECOND_INV_BIT = 2;
  localparam int          SPI_TX_SECOND_INV_BIT = 3;
  localparam int          SPI_FIRST_SEL_BIT    = 4;
  localparam int          SPI_SECOND_SEL_BIT   = 5;
  // Number of serial channels
  localparam int          SPI_CHANNELS         = 2;
endpackage

// file: logic/spi_lane_if.sv
// Interface carrying the per-channel pin data between the top and the lane module.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface spi_lane_if;
  logic [1:0] rx_pin;     // Raw receive pin levels
  logic [1:0] rx_unit;    // Receive data toward the serial units
  logic [1:0] tx_unit;    // Transmit data from the serial units
  logic [1:0] tx_pin;     // Transmit data toward the pins
  logic [1:0] rx_inv;     // Receive inversion controls
  logic [1:0] tx_inv;     // Transmit inversion controls
  modport top  (output rx_pin, tx_unit, rx_inv, tx_inv, input rx_unit, tx_pin);
  modport lane (input rx_pin, tx_unit, rx_inv, tx_inv, output rx_unit, tx_pin);
endinterface

// file: logic/spi_lane.sv
// Per-channel inversion of receive and transmit data.
// Assumes the controls come from registered state in the top.
`timescale 1ns/1ps
module spi_lane
  import spi_pkg::*;
(
  spi_lane_if.lane lanes
);
  // One complement stage per channel; combinational so the pin sees no extra delay
  genvar ch;
  generate
    for (ch = 0; ch < SPI_CHANNELS; ch++)
    begin : g_ch
      assign lanes.rx_unit[ch] = lanes.rx_pin[ch] ^ lanes.rx_inv[ch];
      assign lanes.tx_pin[ch]  = lanes.tx_unit[ch] ^ lanes.tx_inv[ch];
    end
  endgenerate
endmodule

// file: logic/spi_top.sv
// Serial pin inversion and shared-pin select, with an APB register slave.
// Assumes APB signals and pins synchronous to ref_clk; the serial units are elsewhere.
//
// Notes on behaviour
// - Bit 0 inverts first receive data
// - Bit 1 inverts first transmit data
// - Bit 2 inverts second receive data
// - Bit 3 inverts second transmit data
// - Bit 4 routes first transmit to pin
// - Bit 5 routes second transmit to pin
// - Reset loads control register with c0
// - Second select routes pin; enable after select
// - Bits 7 and 6 read one, unwritable
`timescale 1ns/1ps
module spi_top
  import spi_pkg::*;
(
  input  wire logic        ref_clk,             // System clock, 10 MHz
  input  wire logic        reset,               // Synchronous reset, active high
  input  wire logic        clk_en,              // Freezes all state while low unless reset is high
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB access phase
  input  wire logic        pwrite,              // APB direction
  input  wire logic [31:0] paddr,               // APB byte address
  input  wire logic [31:0] pwdata,              // APB write data
  input  wire logic [3:0]  pstrb,               // APB byte strobes
  output logic             pready,              // APB ready
  output logic [31:0]      prdata,              // APB read data
  output logic             pslverr,             // APB error, unmapped address
  input  wire logic        first_receive_pin,   // First channel receive pin
  input  wire logic        second_receive_pin,  // Second channel receive pin
  output logic             first_rx_data,       // First receive data to serial unit
  output logic             second_rx_data,      // Second receive data to serial unit
  input  wire logic        first_tx_data,       // First serial unit transmit data
  input  wire logic        second_tx_data,      // Second serial unit transmit data
  input  wire logic        port3_bit5_out,      // Port output data for shared pin one
  input  wire logic        port3_bit5_oe,       // Port output enable for shared pin one
  input  wire logic        port4_bit2_out,      // Port output data for shared pin two
  input  wire logic        port4_bit2_oe,       // Port output enable for shared pin two
  input  wire logic        first_transmit_pin_in,  // Level seen on shared pin one
  input  wire logic        second_transmit_pin_in, // Level seen on shared pin two
  output logic             first_transmit_pin_out, // Drive for shared pin one
  output logic             first_transmit_pin_oe,  // Enable for shared pin one
  output logic             second_transmit_pin_out, // Drive for shared pin two
  output logic             second_transmit_pin_oe,  // Enable for shared pin two
  output logic             port3_bit5_in,       // Shared pin one level back to port
  output logic             port4_bit2_in,       // Shared pin two level back to port
  output logic [7:0]       serial_pin_inversion_control // Current control byte
);
  logic [7:0]  ctrl_reg;       // Control register
  logic [7:0]  ctrl_next;      // Its next value
  logic [31:0] rdata_reg;      // Read data flop
  logic [31:0] rdata_next;     // Its next value
  logic        hit;            // Address matches the control register
  logic        access;         // APB access phase
  logic        wr_en;          // Write to the control register this cycle
  logic        rd_ask;         // Read waiting for its data to be captured
  logic        rd_fresh_reg;   // Read data captured, transfer may complete
  logic        rd_fresh_next;  // Its next value
  // Named control fields
  logic        rx_first_invert;       // Invert first receive data
  logic        tx_first_invert;       // Invert first transmit data
  logic        rx_second_invert;      // Invert second receive data
  logic        tx_second_invert;      // Invert second transmit data
  logic        first_tx_pin_select;   // Shared pin one carries first transmit
  logic        second_tx_pin_select;  // Shared pin two carries second transmit
  spi_lane_if  lanes();        // Link to the inversion lanes

  // Address decode; only one word is mapped
  always_comb
  begin
    access = psel & penable;
    if (paddr == SPI_CTRL_ADDR)
    begin
      hit = 1'b1;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // Write strobe: a setup cycle alone never changes the register
  assign wr_en   = access & pwrite & hit & pstrb[0];
  // A read asks for capture until its data flop has been loaded
  assign rd_ask  = psel & ~pwrite & ~rd_fresh_reg;
  // Writes need no wait; a read waits until its data flop holds the word.
  // If the clock enable froze the setup edge, the read is held back a cycle
  // instead of handing over stale data. A low clock enable stalls everything.
  assign pready  = clk_en & (pwrite | rd_fresh_reg);
  // Only one word is mapped; anything else is answered with an error
  assign pslverr = access & ~hit;

  // Next control value; byte lane 0 only, top two bits forced to one
  always_comb
  begin
    ctrl_next = ctrl_reg;
    // Only byte lane 0 carries the register; other lanes are ignored
    if (wr_en)
    begin
      ctrl_next = pwdata[7:0] | SPI_CTRL_FIXED_ONES;
    end
  end

  // Read data: fixed ones plus stored bits, zero above the byte
  always_comb
  begin
    rdata_next = rdata_reg;
    // Capture once per read, in its first enabled cycle
    if (rd_ask)
    begin
      if (hit)
      begin
        rdata_next = {24'h000000, ctrl_next | SPI_CTRL_FIXED_ONES};
      end
      else
      begin
        rdata_next = 32'h00000000;  // Unmapped reads return zero
      end
    end
  end

  // Read capture flag: set once the word is loaded, cleared as the transfer ends
  always_comb
  begin
    rd_fresh_next = rd_fresh_reg;
    if (access && pready)
    begin
      rd_fresh_next = 1'b0;  // Transfer taken, next read captures afresh
    end
    else if (rd_ask)
    begin
      rd_fresh_next = 1'b1;  // Data flop loads at this edge
    end
  end

  // Control register; writes land at the access edge, so lanes see them next cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl_reg <= SPI_CTRL_RESET;
    end
    else if (clk_en)
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Read path flops; outside reset, frozen with everything else while the clock enable is low
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rdata_reg    <= 32'h00000000;
      rd_fresh_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_reg    <= rdata_next;
      rd_fresh_reg <= rd_fresh_next;
    end
  end

  assign prdata                       = rdata_reg;
  assign serial_pin_inversion_control = ctrl_reg;

  // Control fields, named once so the muxes below read plainly
  assign rx_first_invert      = ctrl_reg[SPI_RX_FIRST_INV_BIT];
  assign tx_first_invert      = ctrl_reg[SPI_TX_FIRST_INV_BIT];
  assign rx_second_invert     = ctrl_reg[SPI_RX_SECOND_INV_BIT];
  assign tx_second_invert     = ctrl_reg[SPI_TX_SECOND_INV_BIT];
  assign first_tx_pin_select  = ctrl_reg[SPI_FIRST_SEL_BIT];
  assign second_tx_pin_select = ctrl_reg[SPI_SECOND_SEL_BIT];

  // Hook the lanes to the pins and controls
  assign lanes.rx_pin = {second_receive_pin, first_receive_pin};
  assign lanes.tx_unit = {second_tx_data, first_tx_data};
  assign lanes.rx_inv = {rx_second_invert, rx_first_invert};
  assign lanes.tx_inv = {tx_second_invert, tx_first_invert};

  spi_lane u_lane
  (
    .lanes (lanes.lane)
  );

  assign first_rx_data  = lanes.rx_unit[0];
  assign second_rx_data = lanes.rx_unit[1];

  // Shared pin one: serial transmit when selected, else ordinary port I/O.
  // The transmitter drives whenever selected, so the enable bit ordering is software's job.
  always_comb
  begin
    if (first_tx_pin_select)
    begin
      first_transmit_pin_out = lanes.tx_pin[0];
      first_transmit_pin_oe  = 1'b1;
    end
    else
    begin
      first_transmit_pin_out = port3_bit5_out;
      first_transmit_pin_oe  = port3_bit5_oe;
    end
  end

  // Shared pin two, same scheme
  always_comb
  begin
    if (second_tx_pin_select)
    begin
      second_transmit_pin_out = lanes.tx_pin[1];
      second_transmit_pin_oe  = 1'b1;
    end
    else
    begin
      second_transmit_pin_out = port4_bit2_out;
      second_transmit_pin_oe  = port4_bit2_oe;
    end
  end

  // Port side always sees the pin level
  assign port3_bit5_in = first_transmit_pin_in;
  assign port4_bit2_in = second_transmit_pin_in;
endmodule

// file: bench/spi_pin_model.sv
// Far-side serial device for one channel: sends a line level, sees its shared pin.
// Assumes a pull-up on the shared pin.
`timescale 1ns/1ps
module spi_pin_model (
  input  wire logic lvl,  // Level the device sends
  input  wire logic out,  // Block drive on shared pin
  input  wire logic oe,   // Block enable on shared pin
  output logic      rx,   // Receive pin level
  output logic      pin   // Resolved shared pin
);
  assign rx = lvl;
  // Released pin goes to the pull-up, never the last driven value
  assign pin = oe ? out : 1'b1;
endmodule

// file: bench/spi_top_chk.sv
// Checker on the top ports of the pin inversion block.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module spi_top_chk
  import spi_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        first_receive_pin,
  input wire logic        second_receive_pin,
  input wire logic        first_rx_data,
  input wire logic        second_rx_data,
  input wire logic        first_tx_data,
  input wire logic        second_tx_data,
  input wire logic        port3_bit5_out,
  input wire logic        port3_bit5_oe,
  input wire logic        port4_bit2_out,
  input wire logic        port4_bit2_oe,
  input wire logic        first_transmit_pin_out,
  input wire logic        first_transmit_pin_oe,
  input wire logic        second_transmit_pin_out,
  input wire logic        second_transmit_pin_oe,
  input wire logic [7:0]  serial_pin_inversion_control
);
  wire logic [7:0] c = serial_pin_inversion_control;  // Short alias
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rx1; first_rx_data == (first_receive_pin ^ c[0]); endproperty
  a_rx1: assert property (p_rx1) else $error("first rx data wrong");
  property p_rx2; second_rx_data == (second_receive_pin ^ c[2]); endproperty
  a_rx2: assert property (p_rx2) else $error("second rx data wrong");
  property p_tx1; c[4] |-> first_transmit_pin_out == (first_tx_data ^ c[1]); endproperty
  a_tx1: assert property (p_tx1) else $error("first tx pin wrong");
  property p_oe1; first_transmit_pin_oe == (c[4] | port3_bit5_oe); endproperty
  a_oe1: assert property (p_oe1) else $error("first pin enable wrong");
  property p_pt1; !c[4] |-> first_transmit_pin_out == port3_bit5_out; endproperty
  a_pt1: assert property (p_pt1) else $error("port drive not passed");
  property p_fix; c[7:6] == 2'b11; endproperty
  a_fix: assert property (p_fix) else $error("top bits not one");
  property p_rst; $past(reset) |-> c == SPI_CTRL_RESET; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_chg; $changed(first_receive_pin) && $stable(c) |-> $changed(first_rx_data); endproperty
  a_chg: assert property (p_chg) else $error("rx edge lost");
  property p_tx2; c[5] |-> second_transmit_pin_out == (second_tx_data ^ c[3]); endproperty
  a_tx2: assert property (p_tx2) else $error("second tx pin wrong");
  property p_oe2; second_transmit_pin_oe == (c[5] | port4_bit2_oe); endproperty
  a_oe2: assert property (p_oe2) else $error("second pin enable wrong");
  property p_pt2; !c[5] |-> second_transmit_pin_out == port4_bit2_out; endproperty
  a_pt2: assert property (p_pt2) else $error("second port drive not passed");
  property p_wr;
    psel && penable && pready && pwrite && paddr == SPI_CTRL_ADDR && pstrb[0]
      |=> {24'h000000, c} == (($past(pwdata) & 32'h0000003f) | 32'h000000c0);
  endproperty
  a_wr: assert property (p_wr) else $error("control write not applied");
  property p_keep;
    !(psel && penable && pready && pwrite && paddr == SPI_CTRL_ADDR && pstrb[0])
      |=> $stable(c);
  endproperty
  a_keep: assert property (p_keep) else $error("control changed without write");
endmodule
bind spi_top spi_top_chk u_chk (.*);

// file: bench/test_serial_pin_inversion_select.sv
// Testbench: APB register access and pin checks for the inversion block.
// Assumes spi_top, the pin model and the checker are compiled first.
`timescale 1ns/1ps
module test_serial_pin_inversion_select
  import spi_pkg::*;
();
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, d = 0, er;
  logic [31:0] paddr = 0, pwdata = 0, rd, prdata;
  logic pready, pslverr, first_rx_data, second_rx_data, port3_bit5_in, port4_bit2_in;
  logic first_transmit_pin_out, first_transmit_pin_oe, second_transmit_pin_out;
  logic second_transmit_pin_oe;
  logic [7:0] serial_pin_inversion_control;
  logic [7:0] tv [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h3f};
  int n_mismatch = 0, compares = 0;
  // Serial data and port enables follow d; port drive data follows ~d
  wire logic first_tx_data = d, second_tx_data = d, port3_bit5_oe = d, port4_bit2_oe = d;
  wire logic port3_bit5_out = ~d, port4_bit2_out = ~d;
  logic clk_en = 1'b1;
  logic [3:0] pstrb = 4'hf;
  wire logic first_receive_pin, second_receive_pin, first_transmit_pin_in, second_transmit_pin_in;
  wire logic [31:0] obs = {24'h0, first_rx_data, second_rx_data, first_transmit_pin_out,
    first_transmit_pin_oe, second_transmit_pin_out, second_transmit_pin_oe, port3_bit5_in,
    port4_bit2_in};
  spi_top dut (.*);
  spi_pin_model u_m1 (.lvl(d), .out(first_transmit_pin_out), .oe(first_transmit_pin_oe),
    .rx(first_receive_pin), .pin(first_transmit_pin_in));
  spi_pin_model u_m2 (.lvl(d), .out(second_transmit_pin_out), .oe(second_transmit_pin_oe),
    .rx(second_receive_pin), .pin(second_transmit_pin_in));
  initial forever #50 ref_clk = ~ref_clk;
  // Watchdog: the tests need about 100 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    test_done;
  end
  task test_done;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, x);
    compares++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h %h", $time, s, x);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [31:0] a, wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected pin picture; unselected pins carry the port drive
  function automatic logic [31:0] pin_exp(logic [7:0] v, logic b);
    logic o1, o2;
    o1 = v[4] ? b ^ v[1] : ~b;
    o2 = v[5] ? b ^ v[3] : ~b;
    return {24'h0, b ^ v[0], b ^ v[2], o1, v[4] | b, o2, v[5] | b,
      (v[4] | b) ? o1 : 1'b1, (v[5] | b) ? o2 : 1'b1};
  endfunction
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, SPI_CTRL_ADDR, 32'h0);
    chk(rd, 32'hc0);
    foreach (tv[i])
    begin
      apb(1'b1, SPI_CTRL_ADDR, {24'hffffff, tv[i]});
      apb(1'b0, SPI_CTRL_ADDR, 32'h0);
      chk(rd, {24'h0, 2'b11, tv[i][5:0]});
      for (int b = 0; b < 2; b++)
      begin
        // Serial data moves only once the select write has landed
        @(posedge ref_clk);
        d <= b[0];
        @(negedge ref_clk);
        chk(obs, pin_exp(tv[i], b[0]));
      end
    end
    apb(1'b1, SPI_CTRL_ADDR + 32'h4, 32'h0);
    chk(er, 1'b1);
    // Write without byte lane 0 must leave the register alone
    pstrb <= 4'he;
    apb(1'b1, SPI_CTRL_ADDR, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, SPI_CTRL_ADDR + 32'h4, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    // Read whose setup edge is frozen must not hand over the stale zero
    @(posedge ref_clk);
    clk_en <= 1'b0;
    fork
      apb(1'b0, SPI_CTRL_ADDR, 32'h0);
      begin
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join
    chk(rd, 32'hff);
    test_done;
  end
endmodule
